// >>> fap_pkg.sv
package fap_pkg;
    localparam int ADDR_W = 19;
    localparam logic [18:0] ARRAY_TOP = 19'h7FFFF;
    localparam logic [18:0] BLK_4K = 19'h01000;
    localparam logic [18:0] BLK_64K = 19'h10000;
    localparam logic [18:0] MASK_PAGE = 19'h000FF;
    localparam logic [18:0] MASK_4K = 19'h00FFF;
    localparam logic [18:0] MASK_32K = 19'h07FFF;
    localparam logic [18:0] MASK_64K = 19'h0FFFF;
    localparam logic [7:0] OPC_WR_EN = 8'h06;
    localparam logic [7:0] OPC_WR_DIS = 8'h04;
    localparam logic [7:0] OPC_STAT_WR = 8'h01;
    localparam logic [7:0] OPC_PROG = 8'h02;
    localparam logic [7:0] OPC_ERASE_4K = 8'h20;
    localparam logic [7:0] OPC_ERASE_32K = 8'h52;
    localparam logic [7:0] OPC_ERASE_64K = 8'hD8;
    localparam logic [7:0] OPC_CHIP_A = 8'h60;
    localparam logic [7:0] OPC_CHIP_B = 8'hC7;
    localparam logic [7:0] OPC_RST_EN = 8'h66;
    localparam logic [7:0] OPC_RST_GO = 8'h99;
    localparam logic [12:0] PROG_MIN_BYTES = 13'h0005;
    localparam logic [12:0] ERASE_BYTES = 13'h0004;
    localparam logic [12:0] STAT1_BYTES = 13'h0002;
    localparam logic [12:0] STAT2_BYTES = 13'h0003;
    localparam int SR1_BP_LSB = 2;
    localparam int SR2_CMP_BIT = 6;
    localparam logic [7:0] REG_STATUS = 8'h00;
    localparam logic [7:0] REG_CORE = 8'h04;
    localparam logic [7:0] REG_MODE = 8'h08;
    localparam logic [7:0] REG_PROT_LO = 8'h0C;
    localparam logic [7:0] REG_PROT_HI = 8'h10;
    localparam int ST_BUSY = 0;
    localparam int ST_WEL = 1;
    localparam int ST_ESUS = 2;
    localparam int ST_PSUS = 3;
    localparam int ST_RBUSY = 4;
    localparam int ST_ARMED = 5;
    localparam int ST_BP_LSB = 6;
    localparam int ST_CMP = 11;
    localparam int ST_ANY = 12;
    localparam int CORE_BUSY = 0;
    localparam int CORE_ESUS = 1;
    localparam int CORE_PSUS = 2;
    localparam int MODE_LSB = 0;
    localparam int WRAP_LSB = 8;
    localparam logic [4:0] BP_RST = 5'h00;
    localparam logic CMP_RST = 1'b0;
    localparam int RST_TIME_NS = 30000;
    localparam int CLK_PERIOD_NS = 40;
    localparam int RST_CYCLES = (RST_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [1:0] OP_PROG = 2'h0;
    localparam logic [1:0] OP_ERASE = 2'h1;
    localparam logic [1:0] OP_CHIP = 2'h2;
    typedef struct packed {
        logic any;
        logic [18:0] lo;
        logic [18:0] hi;
    } fap_prot_t;
    typedef struct packed {
        logic [1:0] kind;
        logic [18:0] lo;
        logic [18:0] hi;
    } fap_op_t;
    typedef enum logic [2:0] {
        S_IDLE = 3'b001,
        S_FRAME = 3'b010,
        S_RESET = 3'b100
    } fap_state_t;
endpackage

// >>> fap_protect_reset.sv
`timescale 1ns/10ps
module fap_protect_reset #(
    parameter int RST_CYCLES = fap_pkg::RST_CYCLES
) (
    input wire logic clk, // 25 MHz
    input wire logic rst, // sync, high
    input wire logic ce, // freezes all state when low
    input wire logic spi_cs_n, // chip select pin
    input wire logic spi_sck, // serial clock pin
    input wire logic spi_mosi, // serial data in pin
    input wire logic wp_n, // write-lock pin
    input wire logic [7:0] reg_addr, // register address
    input wire logic [31:0] reg_wdata, // register write data
    input wire logic reg_wr, // write strobe
    input wire logic reg_rd, // read strobe
    output logic [31:0] reg_rdata, // read data, cycle after strobe
    output logic op_go, // accepted program/erase pulse
    output fap_pkg::fap_op_t op, // region of the last accepted or refused operation
    output logic op_refused, // protected program/erase pulse
    output fap_pkg::fap_prot_t prot, // current protected range
    output logic reset_busy, // software reset in progress
    output logic core_abort // reset accepted pulse
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    function automatic fap_pkg::fap_prot_t prot_decode(input logic cmp, input logic [4:0] bp);
        logic [18:0] size;
        logic all;
        logic none;
        fap_pkg::fap_prot_t r;
        size = '0;
        all = 1'b0;
        none = 1'b0;
        r = '0;
        if (bp[2:0] == 3'h0) begin
            none = 1'b1;
        end else if (!bp[4]) begin
            if (bp[2]) begin
                all = 1'b1;
            end else begin
                size = fap_pkg::BLK_64K << (bp[1:0] - 2'h1);
            end
        end else if (bp[2:0] == 3'h7) begin
            all = 1'b1;
        end else begin
            size = fap_pkg::BLK_4K << (bp[2] ? 2'h3 : (bp[1:0] - 2'h1));
        end
        if (!cmp) begin
            r.any = !none;
            if (all) begin
                r.lo = '0;
                r.hi = fap_pkg::ARRAY_TOP;
            end else if (!bp[3]) begin
                r.lo = 19'h00000 - size;
                r.hi = fap_pkg::ARRAY_TOP;
            end else begin
                r.lo = '0;
                r.hi = size - 19'h00001;
            end
        end else begin
            // Complement side: the unprotected part of the plain region
            r.any = !all;
            if (none) begin
                r.lo = '0;
                r.hi = fap_pkg::ARRAY_TOP;
            end else if (!bp[3]) begin
                r.lo = '0;
                r.hi = fap_pkg::ARRAY_TOP - size;
            end else begin
                r.lo = size;
                r.hi = fap_pkg::ARRAY_TOP;
            end
        end
        return r;
    endfunction

    logic [3:0] pin_raw;
    logic [3:0] sync1_q;
    logic [3:0] sync2_q;
    logic cs_prev_q;
    logic sck_prev_q;
    assign pin_raw = {wp_n, spi_mosi, spi_sck, spi_cs_n};

    // Idle level high on every pin, so reset never fakes a select edge
    for (genvar i = 0; i < 4; i++) begin : g_sync
        always_ff @(posedge clk) begin
            if (rst) begin
                sync1_q[i] <= 1'b1;
                sync2_q[i] <= 1'b1;
            end else if (ce) begin
                sync1_q[i] <= pin_raw[i];
                sync2_q[i] <= sync1_q[i];
            end
        end
    end

    logic cs_s;
    logic sck_s;
    logic mosi_s;
    logic wp_n_s;
    assign cs_s = sync2_q[0];
    assign sck_s = sync2_q[1];
    assign mosi_s = sync2_q[2];
    assign wp_n_s = sync2_q[3];

    always_ff @(posedge clk) begin
        if (rst) begin
            cs_prev_q <= 1'b1;
            sck_prev_q <= 1'b1;
        end else if (ce) begin
            cs_prev_q <= cs_s;
            sck_prev_q <= sck_s;
        end
    end

    logic sck_rise;
    logic cs_fall;
    logic cs_rise;
    assign sck_rise = sck_s && !sck_prev_q;
    assign cs_fall = !cs_s && cs_prev_q;
    assign cs_rise = cs_s && !cs_prev_q;

    fap_pkg::fap_state_t state_q;
    logic [15:0] bitcnt_q;
    logic [7:0] shift_q;
    logic [7:0] opcode_q;
    logic [23:0] addr_q;
    logic [7:0] stat1_q;
    logic [7:0] stat2_q;
    logic [15:0] rcnt_q;
    logic wel_q;
    logic armed_q;
    logic busy_q;
    logic esus_q;
    logic psus_q;
    logic [7:0] mode_q;
    logic [2:0] wrap_q;
    logic [4:0] bp_q;
    logic cmp_q;

    logic [12:0] nbytes;
    logic [7:0] new_byte;
    assign nbytes = bitcnt_q[15:3];
    assign new_byte = {shift_q[6:0], mosi_s};

    // Bits on rising serial clock, mode 0 and 3 alike
    always_ff @(posedge clk) begin
        if (rst) begin
            bitcnt_q <= '0;
            shift_q <= '0;
            opcode_q <= '0;
            addr_q <= '0;
            stat1_q <= '0;
            stat2_q <= '0;
        end else if (ce) begin
            if (state_q == fap_pkg::S_IDLE && cs_fall) begin
                bitcnt_q <= '0;
            end else if (state_q == fap_pkg::S_FRAME && sck_rise) begin
                shift_q <= new_byte;
                if (bitcnt_q != 16'hFFFF) begin
                    bitcnt_q <= bitcnt_q + 16'h0001;
                end
                if (bitcnt_q[2:0] == 3'h7) begin
                    if (nbytes == 13'h0000) begin
                        opcode_q <= new_byte;
                    end else if (nbytes < 13'h0004) begin
                        addr_q <= {addr_q[15:0], new_byte};
                    end
                    if (nbytes == 13'h0001) begin
                        stat1_q <= new_byte;
                    end else if (nbytes == 13'h0002) begin
                        stat2_q <= new_byte;
                    end
                end
            end
        end
    end

    logic eval;
    logic is_cmd;
    logic op_valid;
    logic overlap;
    logic write_ok;
    logic go;
    logic refuse;
    logic wrsr_ok;
    logic rst_accept;
    logic [18:0] mask;
    fap_pkg::fap_prot_t cur_prot;
    fap_pkg::fap_op_t op_d;

    always_comb begin
        eval = ce && state_q == fap_pkg::S_FRAME && cs_rise;
        is_cmd = bitcnt_q[2:0] == 3'h0 && nbytes != 13'h0000;
        cur_prot = prot_decode(cmp_q, bp_q);
        op_valid = 1'b0;
        mask = '0;
        op_d.kind = fap_pkg::OP_ERASE;
        case (opcode_q)
            fap_pkg::OPC_PROG: begin
                op_valid = nbytes >= fap_pkg::PROG_MIN_BYTES;
                mask = fap_pkg::MASK_PAGE;
                op_d.kind = fap_pkg::OP_PROG;
            end
            fap_pkg::OPC_ERASE_4K: begin
                op_valid = nbytes == fap_pkg::ERASE_BYTES;
                mask = fap_pkg::MASK_4K;
            end
            fap_pkg::OPC_ERASE_32K: begin
                op_valid = nbytes == fap_pkg::ERASE_BYTES;
                mask = fap_pkg::MASK_32K;
            end
            fap_pkg::OPC_ERASE_64K: begin
                op_valid = nbytes == fap_pkg::ERASE_BYTES;
                mask = fap_pkg::MASK_64K;
            end
            fap_pkg::OPC_CHIP_A, fap_pkg::OPC_CHIP_B: begin
                op_valid = 1'b1;
                mask = fap_pkg::ARRAY_TOP;
                op_d.kind = fap_pkg::OP_CHIP;
            end
            default: begin
                op_valid = 1'b0;
            end
        endcase
        op_d.lo = addr_q[18:0] & ~mask;
        op_d.hi = addr_q[18:0] | mask;
        overlap = cur_prot.any && op_d.lo <= cur_prot.hi && op_d.hi >= cur_prot.lo;
        write_ok = eval && is_cmd && wel_q && !busy_q;
        go = write_ok && op_valid && !overlap;
        refuse = write_ok && op_valid && overlap;
        // only the status write reaches the protection bits
        wrsr_ok = write_ok && opcode_q == fap_pkg::OPC_STAT_WR
            && nbytes >= fap_pkg::STAT1_BYTES && !esus_q && !psus_q;
        rst_accept = eval && is_cmd && opcode_q == fap_pkg::OPC_RST_GO && armed_q;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state_q <= fap_pkg::S_IDLE;
            rcnt_q <= '0;
        end else if (ce) begin
            case (state_q)
                fap_pkg::S_IDLE: begin
                    if (cs_fall) begin
                        state_q <= fap_pkg::S_FRAME;
                    end
                end
                fap_pkg::S_FRAME: begin
                    if (rst_accept) begin
                        state_q <= fap_pkg::S_RESET;
                        rcnt_q <= 16'(RST_CYCLES);
                    end else if (eval) begin
                        state_q <= fap_pkg::S_IDLE;
                    end
                end
                fap_pkg::S_RESET: begin
                    if (rcnt_q <= 16'h0001) begin
                        state_q <= fap_pkg::S_IDLE;
                    end
                    rcnt_q <= rcnt_q - 16'h0001;
                end
                default: begin
                    state_q <= fap_pkg::S_IDLE;
                end
            endcase
        end
    end
    assign reset_busy = state_q == fap_pkg::S_RESET;

    always_ff @(posedge clk) begin
        if (rst) begin
            armed_q <= 1'b0;
        end else if (ce && eval && is_cmd) begin
            armed_q <= opcode_q == fap_pkg::OPC_RST_EN;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            wel_q <= 1'b0;
        end else if (ce) begin
            if (rst_accept) begin
                wel_q <= 1'b0;
            end else if (eval && is_cmd && opcode_q == fap_pkg::OPC_WR_EN) begin
                wel_q <= 1'b1;
            end else if (eval && is_cmd && opcode_q == fap_pkg::OPC_WR_DIS) begin
                wel_q <= 1'b0;
            end else if (go || refuse || wrsr_ok) begin
                wel_q <= 1'b0;
            end
        end
    end

    // new range in force next cycle
    always_ff @(posedge clk) begin
        if (rst) begin
            bp_q <= fap_pkg::BP_RST;
            cmp_q <= fap_pkg::CMP_RST;
        end else if (ce && wrsr_ok && wp_n_s) begin
            bp_q <= stat1_q[fap_pkg::SR1_BP_LSB +: 5];
            if (nbytes >= fap_pkg::STAT2_BYTES) begin
                cmp_q <= stat2_q[fap_pkg::SR2_CMP_BIT];
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            busy_q <= 1'b0;
            esus_q <= 1'b0;
            psus_q <= 1'b0;
            mode_q <= '0;
            wrap_q <= '0;
        end else if (ce) begin
            if (rst_accept) begin
                busy_q <= 1'b0;
                esus_q <= 1'b0;
                psus_q <= 1'b0;
                mode_q <= '0;
                wrap_q <= '0;
            end else if (reg_wr && reg_addr == fap_pkg::REG_CORE) begin
                busy_q <= reg_wdata[fap_pkg::CORE_BUSY];
                esus_q <= reg_wdata[fap_pkg::CORE_ESUS];
                psus_q <= reg_wdata[fap_pkg::CORE_PSUS];
            end else if (reg_wr && reg_addr == fap_pkg::REG_MODE) begin
                mode_q <= reg_wdata[fap_pkg::MODE_LSB +: 8];
                wrap_q <= reg_wdata[fap_pkg::WRAP_LSB +: 3];
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            op_go <= 1'b0;
            op_refused <= 1'b0;
            core_abort <= 1'b0;
            op <= '0;
            prot <= '0;
        end else if (ce) begin
            op_go <= go;
            op_refused <= refuse;
            core_abort <= rst_accept;
            prot <= cur_prot;
            if (go || refuse) begin
                op <= op_d;
            end
        end
    end

    // Data stands only in the cycle after the strobe
    always_ff @(posedge clk) begin
        if (rst) begin
            reg_rdata <= '0;
        end else if (ce) begin
            reg_rdata <= '0;
            if (reg_rd) begin
                if (reg_addr == fap_pkg::REG_STATUS) begin
                    reg_rdata[fap_pkg::ST_BUSY] <= busy_q;
                    reg_rdata[fap_pkg::ST_WEL] <= wel_q;
                    reg_rdata[fap_pkg::ST_ESUS] <= esus_q;
                    reg_rdata[fap_pkg::ST_PSUS] <= psus_q;
                    reg_rdata[fap_pkg::ST_RBUSY] <= reset_busy;
                    reg_rdata[fap_pkg::ST_ARMED] <= armed_q;
                    reg_rdata[fap_pkg::ST_BP_LSB +: 5] <= bp_q;
                    reg_rdata[fap_pkg::ST_CMP] <= cmp_q;
                    reg_rdata[fap_pkg::ST_ANY] <= cur_prot.any;
                end else if (reg_addr == fap_pkg::REG_CORE) begin
                    reg_rdata[fap_pkg::CORE_BUSY] <= busy_q;
                    reg_rdata[fap_pkg::CORE_ESUS] <= esus_q;
                    reg_rdata[fap_pkg::CORE_PSUS] <= psus_q;
                end else if (reg_addr == fap_pkg::REG_MODE) begin
                    reg_rdata[fap_pkg::MODE_LSB +: 8] <= mode_q;
                    reg_rdata[fap_pkg::WRAP_LSB +: 3] <= wrap_q;
                end else if (reg_addr == fap_pkg::REG_PROT_LO) begin
                    reg_rdata[18:0] <= cur_prot.lo;
                end else if (reg_addr == fap_pkg::REG_PROT_HI) begin
                    reg_rdata[18:0] <= cur_prot.hi;
                end
            end
        end
    end

    logic [15:0] rbusy_len_q;
    always_ff @(posedge clk) begin
        if (rst) begin
            rbusy_len_q <= '0;
        end else if (ce) begin
            rbusy_len_q <= reset_busy ? rbusy_len_q + 16'h0001 : 16'h0000;
        end
    end

    sequence exec_s;
        eval && is_cmd && opcode_q == fap_pkg::OPC_RST_GO;
    endsequence
    sequence other_s;
        eval && is_cmd && opcode_q != fap_pkg::OPC_RST_EN;
    endsequence

    wel_gate_a: assert property (op_go || op_refused |-> $past(wel_q) && !$past(busy_q))
        else $error("program or erase acted on without write latch");
    prot_block_a: assert property (op_go |-> !(prot.any && op.lo <= prot.hi && op.hi >= prot.lo))
        else $error("accepted operation overlaps protected range");
    lock_hold_a: assert property (!wp_n_s |=> $stable(bp_q) && $stable(cmp_q))
        else $error("protection bits changed while locked");
    arm_clear_a: assert property (other_s |=> !armed_q)
        else $error("reset stayed armed after another command");
    unarmed_a: assert property (exec_s and !armed_q |=> !reset_busy && !core_abort)
        else $error("reset accepted without enable");
    reset_pair_a: assert property (core_abort |-> $past(armed_q) && reset_busy)
        else $error("reset abort without armed pair");
    reset_clears_a: assert property (core_abort |-> !wel_q && !busy_q && !esus_q && !psus_q
        && mode_q == 8'h00 && wrap_q == 3'h0)
        else $error("volatile state not cleared by reset");
    reset_len_a: assert property ($fell(reset_busy) |-> rbusy_len_q == 16'(RST_CYCLES))
        else $error("reset window length wrong");
    reset_quiet_a: assert property (reset_busy |-> !op_go && !op_refused
        && (core_abort || $stable(wel_q)))
        else $error("command taken during reset window");
    wrsr_apply_a: assert property (wrsr_ok && wp_n_s |=> bp_q == $past(stat1_q[6:2]))
        else $error("unlocked status write not applied");
    range_map_a: assert property (!$past(rst) |-> prot == $past(cur_prot)
        && (cmp_q || bp_q[2:0] != 3'h0 || !cur_prot.any))
        else $error("protected range does not follow the bits");
endmodule

// >>> fap_spi_host.sv
`timescale 1ns/10ps
module fap_spi_host (
    input wire logic go, // start a frame
    input wire logic [5:0] nbits, // bits in the frame
    input wire logic [39:0] data, // sent msb first
    output logic cs_n, // chip select, low in frame
    output logic sck, // serial clock, still between frames
    output logic mosi, // serial data
    output logic busy // frame in flight
);
    initial begin
        cs_n = 1'b1;
        sck = 1'b0;
        mosi = 1'b0;
        busy = 1'b0;
    end
    always @(posedge go) begin
        busy = 1'b1;
        #13 cs_n = 1'b0;
        for (int i = 0; i < nbits; i++) begin
            mosi = data[39 - i];
            #160 sck = 1'b1;
            #160 sck = 1'b0;
        end
        #160 cs_n = 1'b1;
        // No pull on the data line, so never leave the last bit standing
        mosi = ~mosi;
        #200 busy = 1'b0;
    end
endmodule

// >>> test_fap_protect_reset.sv
`timescale 1ns/10ps
module test_fap_protect_reset;
    localparam int P_RST = 100;
    logic clk, rst, ce, wp_n, reg_wr, reg_rd, rd_d, go, cs_n, sck, mosi, busy;
    logic op_go, op_refused, reset_busy, core_abort;
    logic [7:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata, rnd, m;
    logic [5:0] nbits;
    logic [39:0] sdata;
    logic [44:0] t;
    logic [43:0] te;
    fap_pkg::fap_op_t op;
    fap_pkg::fap_prot_t prot;
    logic [31:0] rdq[$];
    logic [43:0] evq[$];
    int fail_count = 0;
    int checks = 0;
    int cyc = 0;
    int rb_n = 0;
    // Last entry leaves the upper eighth protected for the erase tests
    logic [44:0] tbl[11] = '{
        {1'h0, 5'h00, 1'h0, 38'h0}, {1'h1, 5'h04, 1'h0, 38'h0},
        {1'h0, 5'h0B, 1'h1, 19'h00000, 19'h3FFFF}, {1'h0, 5'h11, 1'h1, 19'h7F000, 19'h7FFFF},
        {1'h0, 5'h19, 1'h1, 19'h00000, 19'h00FFF}, {1'h0, 5'h16, 1'h1, 19'h78000, 19'h7FFFF},
        {1'h0, 5'h04, 1'h1, 19'h00000, 19'h7FFFF}, {1'h1, 5'h01, 1'h1, 19'h00000, 19'h6FFFF},
        {1'h1, 5'h19, 1'h1, 19'h01000, 19'h7FFFF}, {1'h1, 5'h00, 1'h1, 19'h00000, 19'h7FFFF},
        {1'h0, 5'h01, 1'h1, 19'h70000, 19'h7FFFF}};

    fap_spi_host host (.go(go), .nbits(nbits), .data(sdata), .cs_n(cs_n), .sck(sck),
        .mosi(mosi), .busy(busy));
    fap_protect_reset #(.RST_CYCLES(P_RST)) dut (.clk(clk), .rst(rst), .ce(ce),
        .spi_cs_n(cs_n), .spi_sck(sck), .spi_mosi(mosi), .wp_n(wp_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .op_go(op_go), .op(op), .op_refused(op_refused), .prot(prot),
        .reset_busy(reset_busy), .core_abort(core_abort));

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction

    task automatic chk(input string nm, input logic [43:0] e, input logic [43:0] s);
        checks++;
        if (s !== e) begin
            $display("ERROR %s expected %h seen %h", nm, e, s);
            fail_count++;
        end
    endtask

    task automatic complete_run;
        if (rdq.size() != 0 || evq.size() != 0) fail_count++;
        if (fail_count == 0 && checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk);
        rdq.push_back(e);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
    endtask

    task automatic frame(input logic [5:0] n, input logic [39:0] d);
        int k;
        @(posedge clk);
        nbits <= n;
        sdata <= d;
        go <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
        k = 0;
        while (busy && k < 400) begin
            @(posedge clk);
            k++;
        end
        repeat (8) @(posedge clk);
    endtask

    task automatic cmd(input logic [7:0] b);
        frame(6'd8, {b, 32'h0});
    endtask

    task automatic act(input logic [7:0] c, input logic [18:0] a, input logic [43:0] e);
        cmd(8'h06);
        evq.push_back(e);
        rnd = xs(rnd);
        frame(c == 8'h02 ? 6'd40 : 6'd32, {c, 5'h00, a, rnd[7:0]});
    endtask

    always @(posedge clk) begin
        rd_d <= reg_rd;
        if (rd_d) chk("reg_rdata", {12'h0, rdq.pop_front()}, {12'h0, reg_rdata});
        if (op_go || op_refused || core_abort) begin
            te = evq.pop_front();
            chk("event", te[42:0], {core_abort, op_refused, op_go, te[42] ? 40'h0 : op});
        end
        if (reset_busy === 1'b1) rb_n <= rb_n + 1;
        else if (rb_n != 0) begin
            chk("reset_busy", P_RST, rb_n);
            rb_n <= 0;
        end
        cyc++;
        if (cyc == 20000) begin
            fail_count++;
            complete_run();
        end
    end

    initial begin
        {rst, ce, wp_n} = 3'b111;
        {reg_wr, reg_rd, go} = 3'h0;
        reg_addr = 8'h00;
        reg_wdata = 32'h0;
        nbits = 6'h00;
        sdata = 40'h0;
        rnd = 32'hF478;
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        repeat (3) @(posedge clk);
        rd(8'hFC, 32'h0);
        wr(8'h00, 32'hFFFFFFFF);
        rd(8'h00, 32'h0);
        frame(6'd24, {8'h01, 8'h04, 8'h40, 16'h0});
        rd(8'h00, 32'h0);
        foreach (tbl[i]) begin
            t = tbl[i];
            cmd(8'h06);
            frame(6'd24, {8'h01, 1'b0, t[43:39], 2'b00, 1'b0, t[44], 6'h00, 16'h0});
            rd(8'h00, {19'h0, t[38], t[44], t[43:39], 6'h00});
            if (t[38]) begin
                chk("prot", t[38:0], prot);
                rd(8'h0C, {13'h0, t[37:19]});
                rd(8'h10, {13'h0, t[18:0]});
            end
        end
        wp_n <= 1'b0;
        cmd(8'h06);
        frame(6'd24, {8'h01, 8'h10, 8'h40, 16'h0});
        rd(8'h00, 32'h1040);
        wp_n <= 1'b1;
        rd(8'h0C, 32'h70000);
        frame(6'd7, {8'h06, 32'h0});
        rd(8'h00, 32'h1040);
        frame(6'd32, {8'h20, 32'h0});
        act(8'h20, 19'h7F123, {3'b010, 2'h1, 19'h7F000, 19'h7FFFF});
        act(8'h20, 19'h6FABC, {3'b001, 2'h1, 19'h6F000, 19'h6FFFF});
        act(8'hD8, 19'h65432, {3'b001, 2'h1, 19'h60000, 19'h6FFFF});
        act(8'h52, 19'h78000, {3'b010, 2'h1, 19'h78000, 19'h7FFFF});
        act(8'h60, 19'h00000, {3'b010, 2'h2, 19'h00000, 19'h7FFFF});
        act(8'h02, 19'h70000, {3'b010, 2'h0, 19'h70000, 19'h700FF});
        for (int i = 0; i < 3; i++) begin
            rnd = xs(rnd);
            m = {13'h0, rnd[18:0] & 19'h6FFFF};
            act(8'h02, m[18:0], {3'b001, 2'h0, m[18:8], 8'h00, m[18:8], 8'hFF});
        end
        rnd = xs(rnd);
        m = {21'h0, rnd[10:0]};
        wr(8'h08, m);
        wr(8'h04, 32'h6);
        rd(8'h08, m);
        cmd(8'h66);
        rd(8'h00, 32'h106C);
        cmd(8'h04);
        cmd(8'h99);
        rd(8'h00, 32'h104C);
        cmd(8'h66);
        evq.push_back({3'b100, 40'h0});
        cmd(8'h99);
        cmd(8'h06);
        repeat (40) @(posedge clk);
        rd(8'h04, 32'h0);
        rd(8'h08, 32'h0);
        rd(8'h00, 32'h1040);
        // Second reset from idle, with the write latch set
        cmd(8'h06);
        cmd(8'h66);
        evq.push_back({3'b100, 40'h0});
        cmd(8'h99);
        repeat (P_RST) @(posedge clk);
        rd(8'h00, 32'h1040);
        repeat (4) @(posedge clk);
        complete_run();
    end
endmodule
